// file: core/l2_mode_pkg.sv
// Package for the L2 cache mode and control block: control word layout and policy encodings.
// Assumes a 32-bit control word written as a whole by the core's special-register path.
package l2_mode_pkg;
    localparam int unsigned CTRL_WIDTH = 32;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Bit positions of the control word.
    localparam int unsigned BIT_CACHE_ENABLE     = 0;
    localparam int unsigned BIT_DATA_ONLY        = 9;
    localparam int unsigned BIT_GLOBAL_INVALIDATE = 10;
    localparam int unsigned BIT_RAM_SLEEP_CONTROL = 11;
    localparam int unsigned BIT_WRITE_THROUGH    = 12;
    localparam int unsigned BIT_TEST_SUPPORT     = 13;
    localparam int unsigned BIT_HOLD_LO          = 14;
    localparam int unsigned BIT_HOLD_HI          = 15;
    localparam int unsigned BIT_DLL_SLOW         = 16;
    localparam int unsigned BIT_DIFF_CLOCK       = 17;
    localparam int unsigned BIT_DLL_BYPASS       = 18;
    localparam int unsigned BIT_RSVD_LO          = 19;
    localparam int unsigned BIT_RSVD_HI          = 20;
    localparam int unsigned BIT_INSTRUCTION_ONLY = 21;
    localparam int unsigned BIT_SRAM_CLOCK_STOP  = 22;
    localparam int unsigned BIT_INVALIDATE_BUSY  = 31;
    // Bit 0 and bits 9 to 22 are stored as written; bit 31 reads as invalidate busy, all others as zero.
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h007F_FE01;
    // Coherence state written into a line on an allocating or updating write.
    typedef enum logic [1:0] {
        LINE_INVALID,
        LINE_EXCLUSIVE,
        LINE_MODIFIED
    } line_state_t;
    // Routing decision for one L1 transaction.
    typedef enum logic [2:0] {
        ROUTE_L2_ONLY,
        ROUTE_L2_AND_BUS,
        ROUTE_BUS_BYPASS,
        ROUTE_BUS_INVALIDATE,
        ROUTE_DROP
    } route_t;
    typedef enum logic [2:0] {
        KIND_IFETCH,
        KIND_READ,
        KIND_WRITE,
        KIND_PUSH,
        KIND_ZERO,
        KIND_STORE_MISS_SINGLE
    } kind_t;
endpackage

// file: core/l2_policy_if.sv
// Interface carrying the decoded mode bits from the control register to the policy logic.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface l2_policy_if;
    logic enable;
    logic data_only;
    logic instr_only;
    logic write_through;
    logic test_support;
    modport ctrl (output enable, output data_only, output instr_only, output write_through,
                  output test_support);
    modport policy (input enable, input data_only, input instr_only, input write_through,
                    input test_support);
endinterface
`default_nettype wire

// file: core/l2_tag_invalidator.sv
// Tag state array and global invalidation walker for the L2 cache.
// Assumes tag lookups and updates arrive from the policy path one per cycle.
`timescale 1ns/1ps
`default_nettype none
module l2_tag_invalidator #(
    parameter int unsigned LINES = 256
) (
    // Clock, reset, enable.
    input  wire logic                       i_core_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_ce,
    // Invalidate start and status.
    input  wire logic                       i_start,
    output logic                            o_busy,
    // Lookup and update port.
    input  wire logic [$clog2(LINES)-1:0]   i_index,
    output l2_mode_pkg::line_state_t        o_state,
    input  wire logic                       i_update,
    input  wire l2_mode_pkg::line_state_t   i_new_state
);
    l2_mode_pkg::line_state_t tags [LINES];
    logic [$clog2(LINES)-1:0] walk;
    logic [$clog2(LINES)-1:0] next_walk;
    logic                     busy;
    logic                     next_busy;
    localparam int unsigned              IDX_W = $clog2(LINES);
    localparam logic [$clog2(LINES)-1:0] LAST  = IDX_W'(LINES - 1);

    // Walker advances one line per cycle until every line is cleared.
    always_comb begin
        next_walk = walk;
        next_busy = busy;
        if (!busy && i_start) begin
            next_busy = 1'b1;
            next_walk = '0;
        end else if (busy) begin
            next_walk = walk + 1'b1;
            if (walk == LAST) begin
                next_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            walk <= '0;
            busy <= 1'b0;
        end else if (i_ce) begin
            walk <= next_walk;
            busy <= next_busy;
        end
    end

    // Tag array: invalidation walk clears state bits and beats normal updates.
    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            if (busy) begin
                tags[walk] <= l2_mode_pkg::LINE_INVALID;
            end else if (i_update) begin
                tags[i_index] <= i_new_state;
            end
        end
    end

    assign o_state = busy ? l2_mode_pkg::LINE_INVALID : tags[i_index];
    assign o_busy  = busy;
endmodule
`default_nettype wire

// file: core/l2_mode_control.sv
// Top of the L2 cache mode and control block: control register, routing policy, SRAM power pins.
// Assumes the core presents one transaction per cycle and signals nap or sleep as levels.
//
// Overview of operation
// - Global invalidate clears every line's tag state, status bits included.
// - With RAM control set, low-power output follows nap or sleep state.
// - Write-through forwards L2 writes onto the bus, bar test-support single-beat store misses; otherwise write-back.
// - Write-through writes mark the line exclusive, never modified.
// - Test support keeps flush and store pushes in L2, valid.
// - Test support suppresses zero-block broadcasts and single-beat store miss writes.
// - Output-hold field selects RAM output hold; zero means least hold.
// - DLL-slow lengthens each delay tap; kept zero above 100 MHz.
// - Two reserved bits are stored but unused; software keeps them zero.
// - Instruction-only: data hits serviced, data misses bypass as cache-inhibited.
// - Data-only plus instruction-only locks the cache: no allocation, write hits update.
// - Instruction-only may change at any time, even while enabled.
// - Clock-stop halts SRAM clocks in nap or sleep, restarts on exit or on a snoop during nap.
// - Clock-stop gates only SRAM clocks; DLL feedback keeps running.
// - Enable starts caching and snooping from the next transaction received.
// - Data-only: instruction hits serviced, instruction misses bypass as cache-inhibited.
// - Hard or power-on reset clears the whole control register.
`timescale 1ns/1ps
`default_nettype none
module l2_mode_control #(
    parameter int unsigned LINES = 256
) (
    // Clock, reset and clock enable.
    input  wire logic                       i_core_clk,
    input  wire logic                       i_rst,
    input  wire logic                       i_ce,
    // Control register access.
    input  wire logic                       i_ctrl_write,
    input  wire logic [31:0]                i_ctrl_wdata,
    output logic [31:0]                     o_ctrl_rdata,
    // Power state of the core.
    input  wire logic                       i_nap,
    input  wire logic                       i_sleep,
    input  wire logic                       i_snoop_active,
    // Transaction request from the L1 side.
    input  wire logic                       i_req_valid,
    input  wire l2_mode_pkg::kind_t         i_req_kind,
    input  wire logic [$clog2(LINES)-1:0]   i_req_index,
    // Routing decision.
    output logic                            o_rsp_valid,
    output l2_mode_pkg::route_t             o_rsp_route,
    output logic                            o_rsp_hit,
    output logic                            o_rsp_allocate,
    // SRAM-side pins and settings.
    output logic                            o_sram_low_power_out,
    output logic                            o_sram_clock_run,
    output logic                            o_dll_feedback_run,
    output logic [1:0]                      o_output_hold_sel,
    output logic                            o_dll_slow,
    output logic                            o_differential_clock_mode,
    output logic                            o_dll_bypass
);
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic        inv_busy;
    logic        inv_start;
    logic        walk_busy;
    logic        enabled_live;
    l2_mode_pkg::line_state_t tag_state;
    logic        tag_update;
    l2_mode_pkg::line_state_t tag_new_state;

    l2_policy_if pol ();

    // Control word: write stores masked bits; the invalidate bit self-clears when the walk ends.
    always_comb begin
        next_ctrl = ctrl;
        if (i_ctrl_write) begin
            next_ctrl = i_ctrl_wdata & l2_mode_pkg::CTRL_WRITE_MASK;
        end else if (ctrl[l2_mode_pkg::BIT_GLOBAL_INVALIDATE] && !inv_busy && !inv_start) begin
            next_ctrl[l2_mode_pkg::BIT_GLOBAL_INVALIDATE] = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ctrl <= l2_mode_pkg::CTRL_RESET;
        end else if (i_ce) begin
            ctrl <= next_ctrl;
        end
    end

    // Start the walk on a write that sets the invalidate bit.
    assign inv_start = i_ctrl_write && i_ctrl_wdata[l2_mode_pkg::BIT_GLOBAL_INVALIDATE];

    // Requests are refused until the invalidate bit reads clear, one cycle past the walk.
    assign walk_busy = inv_busy || ctrl[l2_mode_pkg::BIT_GLOBAL_INVALIDATE];

    // Enable takes hold for the transaction after the one in flight in the writing cycle.
    assign enabled_live = ctrl[l2_mode_pkg::BIT_CACHE_ENABLE];

    assign pol.enable        = enabled_live;
    assign pol.data_only     = ctrl[l2_mode_pkg::BIT_DATA_ONLY];
    assign pol.instr_only    = ctrl[l2_mode_pkg::BIT_INSTRUCTION_ONLY];
    assign pol.write_through = ctrl[l2_mode_pkg::BIT_WRITE_THROUGH];
    assign pol.test_support  = ctrl[l2_mode_pkg::BIT_TEST_SUPPORT];

    l2_tag_invalidator #(
        .LINES (LINES)
    ) u_tags (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_start     (inv_start),
        .o_busy      (inv_busy),
        .i_index     (i_req_index),
        .o_state     (tag_state),
        .i_update    (tag_update),
        .i_new_state (tag_new_state)
    );

    // Routing decision for the current transaction.
    l2_mode_pkg::route_t next_route;
    logic                next_hit;
    logic                next_alloc;
    logic                next_rsp_valid;
    logic                hit;
    logic                locked;
    always_comb begin
        hit            = pol.enable && (tag_state != l2_mode_pkg::LINE_INVALID);
        locked         = pol.data_only && pol.instr_only;
        next_route     = l2_mode_pkg::ROUTE_BUS_BYPASS;
        next_alloc     = 1'b0;
        tag_update     = 1'b0;
        tag_new_state  = l2_mode_pkg::LINE_INVALID;
        next_rsp_valid = i_req_valid;
        if (i_req_valid && pol.enable && !walk_busy) begin
            case (i_req_kind)
                l2_mode_pkg::KIND_IFETCH: begin
                    if (hit) begin
                        next_route = l2_mode_pkg::ROUTE_L2_ONLY;
                    end else if (!pol.data_only && !locked) begin
                        next_route = l2_mode_pkg::ROUTE_L2_ONLY;
                        next_alloc = 1'b1;
                        tag_update = 1'b1;
                        tag_new_state = l2_mode_pkg::LINE_EXCLUSIVE;
                    end
                end
                l2_mode_pkg::KIND_READ, l2_mode_pkg::KIND_WRITE,
                l2_mode_pkg::KIND_STORE_MISS_SINGLE: begin
                    if (hit || (!pol.instr_only && !locked)) begin
                        next_alloc = !hit;
                        if (i_req_kind == l2_mode_pkg::KIND_READ) begin
                            next_route = l2_mode_pkg::ROUTE_L2_ONLY;
                            tag_update = !hit;
                            tag_new_state = l2_mode_pkg::LINE_EXCLUSIVE;
                        end else begin
                            tag_update = 1'b1;
                            if (pol.write_through) begin
                                tag_new_state = l2_mode_pkg::LINE_EXCLUSIVE;
                                next_route = l2_mode_pkg::ROUTE_L2_AND_BUS;
                            end else begin
                                tag_new_state = l2_mode_pkg::LINE_MODIFIED;
                                next_route = l2_mode_pkg::ROUTE_L2_ONLY;
                            end
                            if (pol.test_support && !hit
                                && i_req_kind == l2_mode_pkg::KIND_STORE_MISS_SINGLE) begin
                                next_route = l2_mode_pkg::ROUTE_L2_ONLY;
                            end
                        end
                    end
                end
                l2_mode_pkg::KIND_PUSH: begin
                    if (pol.test_support) begin
                        next_route = l2_mode_pkg::ROUTE_L2_ONLY;
                        tag_update = 1'b1;
                        tag_new_state = l2_mode_pkg::LINE_EXCLUSIVE;
                    end else if (hit) begin
                        next_route = l2_mode_pkg::ROUTE_BUS_INVALIDATE;
                        tag_update = 1'b1;
                        tag_new_state = l2_mode_pkg::LINE_INVALID;
                    end
                end
                l2_mode_pkg::KIND_ZERO: begin
                    next_route = pol.test_support ? l2_mode_pkg::ROUTE_DROP
                                                  : l2_mode_pkg::ROUTE_BUS_BYPASS;
                end
                default: begin
                    next_route = l2_mode_pkg::ROUTE_BUS_BYPASS;
                end
            endcase
        end
        next_hit = hit && i_req_valid && !walk_busy;
    end

    // Power pins: low-power and clock run follow nap or sleep while enabled by their bits.
    logic low_power_mode;
    logic next_low_power;
    logic next_clock_run;
    always_comb begin
        low_power_mode = i_nap || i_sleep;
        next_low_power = ctrl[l2_mode_pkg::BIT_RAM_SLEEP_CONTROL] && low_power_mode;
        next_clock_run = !(ctrl[l2_mode_pkg::BIT_SRAM_CLOCK_STOP]
                           && (i_sleep || (i_nap && !i_snoop_active)));
    end

    // Registered outputs.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rsp_valid          <= 1'b0;
            o_rsp_route          <= l2_mode_pkg::ROUTE_BUS_BYPASS;
            o_rsp_hit            <= 1'b0;
            o_rsp_allocate       <= 1'b0;
            o_sram_low_power_out <= 1'b0;
            o_sram_clock_run     <= 1'b1;
            o_dll_feedback_run   <= 1'b1;
            o_ctrl_rdata         <= l2_mode_pkg::CTRL_RESET;
        end else if (i_ce) begin
            o_rsp_valid          <= next_rsp_valid;
            o_rsp_route          <= next_route;
            o_rsp_hit            <= next_hit;
            o_rsp_allocate       <= next_alloc;
            o_sram_low_power_out <= next_low_power;
            o_sram_clock_run     <= next_clock_run;
            o_dll_feedback_run   <= 1'b1;
            o_ctrl_rdata         <= next_ctrl | ({31'h0, next_ctrl[l2_mode_pkg::BIT_GLOBAL_INVALIDATE]}
                                                << l2_mode_pkg::BIT_INVALIDATE_BUSY);
        end
    end

    // Analog settings are driven straight from the stored fields.
    assign o_output_hold_sel = ctrl[l2_mode_pkg::BIT_HOLD_HI:l2_mode_pkg::BIT_HOLD_LO];
    assign o_dll_slow                = ctrl[l2_mode_pkg::BIT_DLL_SLOW];
    assign o_differential_clock_mode = ctrl[l2_mode_pkg::BIT_DIFF_CLOCK];
    assign o_dll_bypass              = ctrl[l2_mode_pkg::BIT_DLL_BYPASS];
endmodule
`default_nettype wire

// file: verification/l2_mode_chk.sv
// Checker for the L2 mode block, bound to its top module.
// Assumes one core clock and a synchronous reset that is active high.
`timescale 1ns/1ps
`default_nettype none
module l2_mode_chk (
    // Clock, reset and the watched inputs.
    input wire logic        i_core_clk, i_rst, i_ce, i_nap, i_sleep, i_snoop_active, i_req_valid,
    input wire l2_mode_pkg::kind_t  i_req_kind,
    // Watched outputs.
    input wire logic [31:0] o_ctrl_rdata,
    input wire logic        o_rsp_valid, o_rsp_hit, o_rsp_allocate,
    input wire l2_mode_pkg::route_t o_rsp_route,
    input wire logic        o_sram_low_power_out, o_sram_clock_run, o_dll_feedback_run,
    input wire logic [1:0]  o_output_hold_sel
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Stored control bits and the derived power conditions.
    logic [31:0] c;
    logic        stop_cond;
    logic        ts_on;
    assign c = o_ctrl_rdata;
    assign stop_cond = i_sleep || (i_nap && !i_snoop_active);
    assign ts_on = c[13] && c[0] && !c[31] && !c[21];
    // A request of a given kind taken at this edge.
    sequence req_s(k);
        i_ce && i_req_valid && i_req_kind == k;
    endsequence
    sequence any_req_s;
        i_ce && i_req_valid;
    endsequence

    rsp_follows_a: assert property (any_req_s |=> o_rsp_valid)
        else $error("request got no answer");
    off_no_cache_a: assert property (any_req_s ##0 !c[0] |=> !o_rsp_hit && !o_rsp_allocate)
        else $error("disabled cache hit or allocated");
    walk_refuse_a: assert property (any_req_s ##0 c[31] |=> o_rsp_route == l2_mode_pkg::ROUTE_BUS_BYPASS && !o_rsp_hit)
        else $error("request served during invalidate");
    wt_forward_a: assert property (req_s(l2_mode_pkg::KIND_WRITE) ##0 (c[12] && c[0])
        |=> o_rsp_route inside {l2_mode_pkg::ROUTE_L2_AND_BUS, l2_mode_pkg::ROUTE_BUS_BYPASS})
        else $error("write-through write kept off the bus");
    ts_push_a: assert property (req_s(l2_mode_pkg::KIND_PUSH) ##0 ts_on |=> o_rsp_route == l2_mode_pkg::ROUTE_L2_ONLY)
        else $error("test push left the L2");
    ts_zero_a: assert property (req_s(l2_mode_pkg::KIND_ZERO) ##0 ts_on |=> o_rsp_route inside
        {l2_mode_pkg::ROUTE_L2_ONLY, l2_mode_pkg::ROUTE_DROP})
        else $error("zero block broadcast under test support");
    lp_enter_a: assert property ($rose(i_nap || i_sleep) && c[11] |-> ##[1:2] o_sram_low_power_out)
        else $error("low power not asserted");
    lp_exit_a: assert property ((!i_nap && !i_sleep) [*2] |-> !o_sram_low_power_out)
        else $error("low power held when awake");
    clk_stop_a: assert property ((c[22] && stop_cond) [*2] |-> !o_sram_clock_run)
        else $error("SRAM clock runs while stopped");
    clk_run_a: assert property ((!c[22] || !stop_cond) [*2] |-> o_sram_clock_run && o_dll_feedback_run)
        else $error("SRAM or feedback clock stopped");
    hold_pins_a: assert property (o_output_hold_sel == c[15:14] && o_dll_feedback_run)
        else $error("hold select differs from register");
endmodule
bind l2_mode_control l2_mode_chk chk_u (.*);
`default_nettype wire

// file: verification/sram_side_model.sv
// Far-side model of the L2 SRAMs: counts the clock edges they and the DLL loop receive.
// Assumes the gating levels come from the block in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module sram_side_model (
    // Gating levels from the block.
    input  wire logic i_core_clk, i_sram_clock_run, i_dll_feedback_run, i_sram_low_power_out,
    // Edge counts.
    output var int    o_ram_edges, o_sync_edges
);
    // A RAM in low power ignores its clock; the feedback loop counts whenever it runs.
    initial begin
        o_ram_edges = 0;
        o_sync_edges = 0;
    end
    always @(posedge i_core_clk) begin
        if (i_sram_clock_run && !i_sram_low_power_out) o_ram_edges <= o_ram_edges + 1;
        if (i_dll_feedback_run) o_sync_edges <= o_sync_edges + 1;
    end
endmodule
`default_nettype wire

// file: verification/l2_mode_control_bench.sv
// Bench for the L2 mode block: control writes, requests and power levels.
// Assumes the package, design and SRAM side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module l2_mode_control_bench;
    // Design inputs, driven at the rising edge.
    logic        i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_ctrl_write = 1'b0;
    logic        i_nap = 1'b0, i_sleep = 1'b0, i_snoop_active = 1'b0, i_req_valid = 1'b0;
    logic [31:0] i_ctrl_wdata = 32'h0;
    logic [2:0]  i_req_index = 3'h0;
    l2_mode_pkg::kind_t  i_req_kind = l2_mode_pkg::KIND_READ;
    // Design outputs and bench counters.
    logic [31:0] o_ctrl_rdata;
    logic [1:0]  o_output_hold_sel;
    logic        o_rsp_valid, o_rsp_hit, o_rsp_allocate, o_sram_low_power_out, o_sram_clock_run;
    logic        o_dll_feedback_run, o_dll_slow, o_differential_clock_mode, o_dll_bypass;
    l2_mode_pkg::route_t o_rsp_route;
    int          ram_edges, sync_edges, e0, s0, n_mismatch = 0, total_checks = 0;

    // Design with an eight-line tag array, and the RAM side model.
    l2_mode_control #(.LINES(8)) dut_u (.*);
    sram_side_model ram_u (.i_core_clk, .i_sram_clock_run(o_sram_clock_run),
        .i_dll_feedback_run(o_dll_feedback_run), .i_sram_low_power_out(o_sram_low_power_out),
        .o_ram_edges(ram_edges), .o_sync_edges(sync_edges));
    always #2 i_core_clk = ~i_core_clk;

    // Compares one value and counts the result.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Lets n edges pass, then steps past the last so outputs are settled.
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // Writes the whole control word; the readback is settled on return.
    task automatic wr(input logic [31:0] d);
        @(posedge i_core_clk);
        i_ctrl_write <= 1'b1;
        i_ctrl_wdata <= d;
        @(posedge i_core_clk);
        i_ctrl_write <= 1'b0;
        #1;
    endtask
    // Sends one request and compares valid with the masked {hit, allocate} answer.
    task automatic rq(input l2_mode_pkg::kind_t k, input logic [2:0] ix, input logic [1:0] m,
                      input logic [1:0] ha);
        @(posedge i_core_clk);
        i_req_valid <= 1'b1;
        i_req_kind <= k;
        i_req_index <= ix;
        @(posedge i_core_clk);
        i_req_valid <= 1'b0;
        #1;
        check($sformatf("answer %s %0d", k.name(), ix), {o_rsp_valid, {o_rsp_hit, o_rsp_allocate} & m}, {1'b1, ha & m});
    endtask
    // Disables the cache, then runs a global invalidate to its end under a bound.
    task automatic inval();
        int i;
        wr(32'h0);
        wr(32'h0000_0400);
        for (i = 0; i < 40 && o_ctrl_rdata[31] !== 1'b0; i++) tick(1);
        check("walk end", o_ctrl_rdata, 32'h0);
        if (i == 40) wrap_up();
    endtask

    // Reset values, a write ignored while the clock enable is low, stored fields and pins.
    task automatic t_fields();
        check("reset ctrl", o_ctrl_rdata, 32'h0);
        check("reset pins", {o_sram_low_power_out, o_sram_clock_run, o_rsp_valid}, 3'h2);
        @(posedge i_core_clk);
        i_ce <= 1'b0;
        i_ctrl_write <= 1'b1;
        i_ctrl_wdata <= 32'h0000_0200;
        @(posedge i_core_clk);
        i_ce <= 1'b1;
        i_ctrl_write <= 1'b0;
        tick(1);
        check("held ctrl", o_ctrl_rdata, 32'h0);
        wr(32'hFFFF_FBFE);
        check("stored ctrl", o_ctrl_rdata, 32'h007F_FA00);
        check("pins", {o_output_hold_sel, o_dll_slow, o_differential_clock_mode, o_dll_bypass}, 5'h1F);
        wr(32'h0);
        check("pins zero", {o_output_hold_sel, o_dll_slow, o_differential_clock_mode, o_dll_bypass}, 5'h00);
        $display("end t_fields");
    endtask
    // Invalidate progress, refusal during the walk, empty array, write-back, disabled access and write-through.
    task automatic t_cache();
        wr(32'h0000_0400);
        check("walk busy", o_ctrl_rdata, 32'h8000_0400);
        rq(l2_mode_pkg::KIND_READ, 3'h0, 2'h3, 2'h0);
        check("walk route", o_rsp_route, l2_mode_pkg::ROUTE_BUS_BYPASS);
        inval();
        wr(32'h0000_0001);
        for (int i = 0; i < 8; i++) rq(l2_mode_pkg::KIND_READ, i[2:0], 2'h2, 2'h0);
        inval();
        wr(32'h0000_0001);
        rq(l2_mode_pkg::KIND_WRITE, 3'h2, 2'h3, 2'h1);
        rq(l2_mode_pkg::KIND_WRITE, 3'h2, 2'h3, 2'h2);
        check("wb route", o_rsp_route, l2_mode_pkg::ROUTE_L2_ONLY);
        wr(32'h0);
        rq(l2_mode_pkg::KIND_READ, 3'h2, 2'h3, 2'h0);
        wr(32'h0000_0001);
        rq(l2_mode_pkg::KIND_READ, 3'h2, 2'h2, 2'h2);
        inval();
        wr(32'h0000_1000);
        wr(32'h0000_1001);
        rq(l2_mode_pkg::KIND_WRITE, 3'h3, 2'h1, 2'h1);
        rq(l2_mode_pkg::KIND_WRITE, 3'h3, 2'h2, 2'h2);
        check("wt route", o_rsp_route, l2_mode_pkg::ROUTE_L2_AND_BUS);
        $display("end t_cache");
    endtask
    // Instruction-only set while enabled, data-only, then both as a locked cache.
    task automatic t_modes();
        inval();
        wr(32'h0000_0001);
        rq(l2_mode_pkg::KIND_WRITE, 3'h4, 2'h1, 2'h1);
        wr(32'h0020_0001);
        rq(l2_mode_pkg::KIND_READ, 3'h4, 2'h2, 2'h2);
        rq(l2_mode_pkg::KIND_READ, 3'h5, 2'h3, 2'h0);
        check("io route", o_rsp_route, l2_mode_pkg::ROUTE_BUS_BYPASS);
        rq(l2_mode_pkg::KIND_IFETCH, 3'h6, 2'h1, 2'h1);
        wr(32'h0000_0201);
        rq(l2_mode_pkg::KIND_IFETCH, 3'h6, 2'h2, 2'h2);
        rq(l2_mode_pkg::KIND_IFETCH, 3'h7, 2'h3, 2'h0);
        check("do route", o_rsp_route, l2_mode_pkg::ROUTE_BUS_BYPASS);
        wr(32'h0020_0201);
        rq(l2_mode_pkg::KIND_WRITE, 3'h4, 2'h3, 2'h2);
        rq(l2_mode_pkg::KIND_WRITE, 3'h5, 2'h3, 2'h0);
        $display("end t_modes");
    endtask
    // Test-support pushes, zero blocks and single-beat store misses, then a normal push.
    task automatic t_test();
        inval();
        wr(32'h0000_3000);
        wr(32'h0000_3001);
        rq(l2_mode_pkg::KIND_PUSH, 3'h1, 2'h0, 2'h0);
        check("ts push", o_rsp_route, l2_mode_pkg::ROUTE_L2_ONLY);
        rq(l2_mode_pkg::KIND_ZERO, 3'h2, 2'h0, 2'h0);
        check("ts zero", o_rsp_route, l2_mode_pkg::ROUTE_DROP);
        rq(l2_mode_pkg::KIND_STORE_MISS_SINGLE, 3'h3, 2'h0, 2'h0);
        check("ts store", o_rsp_route, l2_mode_pkg::ROUTE_L2_ONLY);
        wr(32'h0000_0001);
        rq(l2_mode_pkg::KIND_PUSH, 3'h1, 2'h2, 2'h2);
        check("push route", o_rsp_route, l2_mode_pkg::ROUTE_BUS_INVALIDATE);
        rq(l2_mode_pkg::KIND_READ, 3'h1, 2'h2, 2'h0);
        $display("end t_test");
    endtask
    // Sleep with low power and clock stop, then nap with snooping, then a second reset.
    task automatic t_power();
        wr(32'h0040_0800);
        i_sleep <= 1'b1;
        tick(3);
        check("sleep pins", {o_sram_low_power_out, o_sram_clock_run}, 2'h2);
        e0 = ram_edges;
        s0 = sync_edges;
        tick(4);
        check("ram edges", ram_edges, e0);
        check("sync edges", sync_edges, s0 + 4);
        i_sleep <= 1'b0;
        tick(3);
        check("awake pins", {o_sram_low_power_out, o_sram_clock_run}, 2'h1);
        wr(32'h0040_0000);
        i_nap <= 1'b1;
        tick(3);
        check("nap pins", {o_sram_low_power_out, o_sram_clock_run}, 2'h0);
        i_snoop_active <= 1'b1;
        tick(3);
        check("snoop pins", {o_sram_low_power_out, o_sram_clock_run}, 2'h1);
        i_nap <= 1'b0;
        i_snoop_active <= 1'b0;
        i_rst <= 1'b1;
        tick(2);
        i_rst <= 1'b0;
        tick(1);
        check("reset again", o_ctrl_rdata, 32'h0);
        $display("end t_power");
    endtask

    // Main sequence: six reset cycles, then every scenario.
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        tick(1);
        t_fields();
        t_cache();
        t_modes();
        t_test();
        t_power();
        wrap_up();
    end
endmodule
`default_nettype wire
